// *** hw/dma_block_transfer.sv ***
// two-channel full-address dma engine with block transfer and activation logic
`timescale 1ns/1ps
`include "dma_consts.svh"
module dma_block_transfer (
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  input  wire logic [5:0]  i_irq_source,
  input  wire logic        i_external_request_n,
  output logic      [5:0]  o_irq_clear,
  output logic      [5:0]  o_cpu_irq,
  output logic      [1:0]  o_end_irq,
  output logic             o_bus_req,
  input  wire logic        i_bus_grant,
  output logic      [23:0] o_bus_addr,
  output logic             o_bus_rd,
  output logic             o_bus_wr,
  output logic             o_bus_word,
  output logic      [15:0] o_bus_wdata,
  input  wire logic [15:0] i_bus_rdata,
  input  wire logic        i_bus_ack,
  output logic             o_ext_addr_drive
);
  // =====================================================================
  // per-channel storage, indexed by channel
  logic [15:0] ctrl       [`CH_COUNT];  // control word
  logic [23:0] src_ptr    [`CH_COUNT];  // source pointer
  logic [23:0] dst_ptr    [`CH_COUNT];  // destination pointer
  logic [23:0] blk_start  [`CH_COUNT];  // block-area pointer at block start
  logic [7:0]  size_hold  [`CH_COUNT];  // block size hold
  logic [7:0]  size_cnt   [`CH_COUNT];  // block size counter
  logic [15:0] blocks     [`CH_COUNT];  // block / transfer counter
  logic [2:0]  sel        [`CH_COUNT];  // request source code
  logic [`CH_COUNT-1:0] end_flag;       // sticky transfer end
  logic [`CH_COUNT-1:0] pending;        // held internal request
  logic [`CH_COUNT-1:0] skip;           // flag already cleared by a peer
  logic [`CH_COUNT-1:0] en;             // channel may transfer
  logic [`CH_COUNT-1:0] blk;            // block mode selected
  logic [`CH_COUNT-1:0] ready;          // channel asks for service
  logic [`CH_COUNT-1:0] unit_c;         // unit finished on this channel
  logic [`CH_COUNT-1:0] last_unit;      // size counter on its last unit
  logic [`CH_COUNT-1:0] last_block;     // block counter on its last count
  logic [`CH_COUNT-1:0] end_c;          // whole transfer ends now
  logic [`CH_COUNT-1:0] start_c;        // channel activated now

  // =====================================================================
  // sequencer and bus state
  dma_pkg::state_t state;               // transfer sequencer
  logic        act;                     // channel owning the sequencer
  logic        act_skip;                // active activation must not clear
  logic        cont;                    // keep bus for another unit
  logic        pick_any;                // some channel is ready
  logic        pick_idx;                // highest-priority ready channel
  logic        start;                   // activation this cycle
  logic        unit_done;               // write acknowledged
  logic        ext_meta;                // external request, first stage
  logic        ext_sync;                // external request, synchronised
  logic [5:0]  irq_prev;                // sources one cycle ago
  logic [5:0]  claim;                   // sources owned by a channel
  logic [5:0]  next_clear;              // flag clears for next cycle
  logic [31:0] next_rdata;              // register read mux
  logic [23:0] presc_addr;              // register that clears active flag

  // =====================================================================
  // channel picker
  dma_priority_pick u_pick (
    .i_req (ready),
    .o_any (pick_any),
    .o_idx (pick_idx)
  );

  assign start     = (state == dma_pkg::st_idle) && pick_any;
  assign unit_done = (state == dma_pkg::st_write) && i_bus_ack;

  // =====================================================================
  // external request synchroniser; only the second stage is read
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      ext_meta <= 1'b1;
      ext_sync <= 1'b1;
    end
    else
    begin
      ext_meta <= i_external_request_n;
      ext_sync <= ext_meta;
    end
  end

  // source history for edge detection
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      irq_prev <= 6'h00;
    else
      irq_prev <= i_irq_source;
  end

  // =====================================================================
  // channel logic
  for (genvar c = 0; c < `CH_COUNT; c++)
  begin : g_ch
    logic        wr_c;                  // software write to this channel
    logic        rise;                  // selected source went high
    logic        area_src;              // source pointer is the block area
    logic [23:0] step;                  // pointer step for this data size
    logic [4:0]  off;                   // register offset
    assign off        = i_addr[4:0];
    assign wr_c       = i_wr && (i_addr[7:6] == 2'b00) && (i_addr[`CH_SEL_BIT] == 1'(c));
    assign sel[c]     = ctrl[c][`CTL_SEL_MSB:`CTL_SEL_LSB];
    assign en[c]      = ctrl[c][`CTL_TE] && ctrl[c][`CTL_MTE] && ctrl[c][`CTL_FULL_ADDR];
    assign blk[c]     = ctrl[c][`CTL_FULL_ADDR] && ctrl[c][`CTL_BLOCK_MODE];
    assign area_src   = ctrl[c][`CTL_AREA_SRC];
    assign step       = ctrl[c][`CTL_WORD] ? `STEP_WORD : `STEP_BYTE;
    assign rise       = (sel[c] < `SEL_EXTERNAL) && i_irq_source[sel[c]] && !irq_prev[sel[c]];
    // zero counts wrap on the first decrement, which yields the full range
    assign last_unit[c]  = (size_cnt[c] == 8'h01);
    assign last_block[c] = (blocks[c] == 16'h0001);
    assign unit_c[c]  = unit_done && (act == 1'(c));
    assign start_c[c] = start && (pick_idx == 1'(c));
    assign end_c[c]   = unit_c[c] && last_block[c] && (!blk[c] || last_unit[c]);
    // block mode takes only internal sources, normal mode only pin or auto
    assign ready[c]   = en[c] && (blk[c] ? ((sel[c] < `SEL_EXTERNAL) && pending[c])
                        : (((sel[c] == `SEL_EXTERNAL) && !ext_sync)
                        || (sel[c] == `SEL_AUTO)));

    // control word; a software write at the end of transfer lands with TE cleared
    always_ff @(posedge i_clk_sys)
    begin
      if (i_reset)
        ctrl[c] <= `CTRL_RESET;
      else if (end_c[c])
        ctrl[c] <= wr_c && (off == `OFF_CTRL) ? (i_wdata[15:0] & ~16'h0001)
                   : (ctrl[c] & ~16'h0001);
      else if (wr_c && (off == `OFF_CTRL))
        ctrl[c] <= i_wdata[15:0];
    end

    // pointers: step per unit, block area restored on reload
    always_ff @(posedge i_clk_sys)
    begin
      if (i_reset)
      begin
        src_ptr[c]   <= `PTR_RESET;
        dst_ptr[c]   <= `PTR_RESET;
        blk_start[c] <= `PTR_RESET;
      end
      else
      begin
        if (start_c[c])
          blk_start[c] <= area_src ? src_ptr[c] : dst_ptr[c];
        if (wr_c && (off == `OFF_SRC_PTR))
          src_ptr[c] <= i_wdata[23:0];
        else if (unit_c[c] && blk[c] && last_unit[c] && area_src)
          src_ptr[c] <= blk_start[c];
        else if (unit_c[c] && ctrl[c][`CTL_SRC_EN])
          src_ptr[c] <= ctrl[c][`CTL_SRC_DEC] ? src_ptr[c] - step : src_ptr[c] + step;
        if (wr_c && (off == `OFF_DST_PTR))
          dst_ptr[c] <= i_wdata[23:0];
        else if (unit_c[c] && blk[c] && last_unit[c] && !area_src)
          dst_ptr[c] <= blk_start[c];
        else if (unit_c[c] && ctrl[c][`CTL_DST_EN])
          dst_ptr[c] <= ctrl[c][`CTL_DST_DEC] ? dst_ptr[c] - step : dst_ptr[c] + step;
      end
    end

    // counters: size counter per unit in block mode, block counter per block, or per unit in normal mode
    always_ff @(posedge i_clk_sys)
    begin
      if (i_reset)
      begin
        size_hold[c] <= `SIZE_RESET;
        size_cnt[c]  <= `SIZE_RESET;
        blocks[c]    <= `BLOCKS_RESET;
      end
      else
      begin
        if (wr_c && (off == `OFF_SIZE))
        begin
          size_hold[c] <= i_wdata[15:8];
          size_cnt[c]  <= i_wdata[7:0];
        end
        else if (unit_c[c] && blk[c])
          size_cnt[c] <= last_unit[c] ? size_hold[c] : size_cnt[c] - 8'h01;
        if (wr_c && (off == `OFF_BLOCKS))
          blocks[c] <= i_wdata[15:0];
        else if (unit_c[c] && (!blk[c] || last_unit[c]))
          blocks[c] <= blocks[c] - 16'h0001;
      end
    end

    // event flags; a hardware set beats the clear in the same cycle
    always_ff @(posedge i_clk_sys)
    begin
      if (i_reset)
      begin
        end_flag[c] <= 1'b0;
        pending[c]  <= 1'b0;
        skip[c]     <= 1'b0;
      end
      else
      begin
        if (end_c[c])
          end_flag[c] <= 1'b1;
        else if (wr_c && (off == `OFF_STATUS) && i_wdata[`STS_END])
          end_flag[c] <= 1'b0;
        // a disabled channel never latches its source
        if (rise && en[c] && blk[c])
          pending[c] <= 1'b1;
        else if (start_c[c])
          pending[c] <= 1'b0;
        // a peer that took the same source first already cleared it
        if (start && !start_c[c] && pending[c] && (sel[pick_idx] == sel[c]))
          skip[c] <= 1'b1;
        else if (start_c[c])
          skip[c] <= 1'b0;
      end
    end
  end

  // =====================================================================
  // end interrupt per channel
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      o_end_irq <= 2'b00;
    else
      o_end_irq <= end_flag & {ctrl[1][`CTL_END_IRQ_EN], ctrl[0][`CTL_END_IRQ_EN]};
  end

  // =====================================================================
  // sources owned by an enabled block-mode channel with activation select set
  always_comb
  begin
    claim = 6'h00;
    for (int k = 0; k < `CH_COUNT; k++)
    begin
      if (en[k] && blk[k] && ctrl[k][`CTL_ACT_SEL] && (sel[k] < `SEL_EXTERNAL))
        claim[sel[k]] = 1'b1;
    end
  end

  // sources reach the processor unless a channel owns them
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      o_cpu_irq <= 6'h00;
    else
      o_cpu_irq <= i_irq_source & ~claim;
  end

  // =====================================================================
  // source flag clears; timer sources clear at activation, the others
  // only when their data register is touched by the transfer
  always_comb
  begin
    case (sel[act])
      3'h0:    presc_addr = `ADC_RESULT_ADDR;
      3'h1:    presc_addr = `TX_DATA_ADDR;
      3'h2:    presc_addr = `RX_DATA_ADDR;
      default: presc_addr = `PTR_RESET;
    endcase
    next_clear = 6'h00;
    // activation select low: the flag is left for the processor
    if (start && ctrl[pick_idx][`CTL_ACT_SEL] && !skip[pick_idx]
        && (sel[pick_idx] >= `SEL_FIRST_FLAG) && (sel[pick_idx] < `SEL_EXTERNAL))
      next_clear[sel[pick_idx]] = 1'b1;
    if ((o_bus_rd || o_bus_wr) && i_bus_ack && ctrl[act][`CTL_ACT_SEL] && !act_skip
        && (sel[act] < `SEL_FIRST_FLAG) && (o_bus_addr == presc_addr))
      next_clear[sel[act]] = 1'b1;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      o_irq_clear <= 6'h00;
    else
      o_irq_clear <= next_clear;
  end

  // =====================================================================
  // transfer sequencer: read then write while holding the bus
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      state            <= dma_pkg::st_idle;
      act              <= 1'b0;
      act_skip         <= 1'b0;
      cont             <= 1'b0;
      o_bus_req        <= 1'b0;
      o_bus_addr       <= `PTR_RESET;
      o_bus_rd         <= 1'b0;
      o_bus_wr         <= 1'b0;
      o_bus_word       <= 1'b0;
      o_bus_wdata      <= 16'h0000;
      o_ext_addr_drive <= 1'b0;
    end
    else
    begin
      case (state)
        dma_pkg::st_idle:
        begin
          if (start)
          begin
            act       <= pick_idx;
            act_skip  <= skip[pick_idx];
            o_bus_req <= 1'b1;
            state     <= dma_pkg::st_req;
          end
        end
        dma_pkg::st_req:
        begin
          if (i_bus_grant)
          begin
            o_bus_addr       <= src_ptr[act];
            o_bus_rd         <= 1'b1;
            o_bus_word       <= ctrl[act][`CTL_WORD];
            o_ext_addr_drive <= (src_ptr[act] < `INTERNAL_BASE);
            state            <= dma_pkg::st_read;
          end
        end
        dma_pkg::st_read:
        begin
          // the bus controller stretches the access for the area timing
          if (i_bus_ack)
          begin
            o_bus_wdata      <= i_bus_rdata;
            o_bus_rd         <= 1'b0;
            o_bus_wr         <= 1'b1;
            o_bus_addr       <= dst_ptr[act];
            o_ext_addr_drive <= (dst_ptr[act] < `INTERNAL_BASE);
            state            <= dma_pkg::st_write;
          end
        end
        dma_pkg::st_write:
        begin
          if (i_bus_ack)
          begin
            o_bus_wr         <= 1'b0;
            o_ext_addr_drive <= 1'b0;
            // a block never breaks; only auto burst holds across units
            cont  <= blk[act] ? !last_unit[act]
                     : (ctrl[act][`CTL_BURST] && (sel[act] == `SEL_AUTO)
                     && !last_block[act]);
            state <= dma_pkg::st_step;
          end
        end
        dma_pkg::st_step:
        begin
          if (cont)
          begin
            o_bus_addr       <= src_ptr[act];
            o_bus_rd         <= 1'b1;
            o_ext_addr_drive <= (src_ptr[act] < `INTERNAL_BASE);
            state            <= dma_pkg::st_read;
          end
          else
          begin
            o_bus_req <= 1'b0;
            state     <= dma_pkg::st_idle;
          end
        end
        default:
          state <= dma_pkg::st_idle;
      endcase
    end
  end

  // =====================================================================
  // register read port, data valid in the cycle after the strobe only
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (i_rd && (i_addr[7:6] == 2'b00))
    begin
      case (i_addr[4:0])
        `OFF_SRC_PTR: next_rdata = {8'h00, src_ptr[i_addr[`CH_SEL_BIT]]};
        `OFF_DST_PTR: next_rdata = {8'h00, dst_ptr[i_addr[`CH_SEL_BIT]]};
        `OFF_SIZE:    next_rdata = {16'h0000, size_hold[i_addr[`CH_SEL_BIT]],
                                    size_cnt[i_addr[`CH_SEL_BIT]]};
        `OFF_BLOCKS:  next_rdata = {16'h0000, blocks[i_addr[`CH_SEL_BIT]]};
        `OFF_CTRL:    next_rdata = {16'h0000, ctrl[i_addr[`CH_SEL_BIT]]};
        `OFF_STATUS:  next_rdata = {30'h0000_0000,
                                    (state != dma_pkg::st_idle) && (act == i_addr[`CH_SEL_BIT]),
                                    end_flag[i_addr[`CH_SEL_BIT]]};
        default:      next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      o_rdata <= 32'h0000_0000;
    else
      o_rdata <= next_rdata;
  end

  // =====================================================================
  // checks
  property p_size_reload;
    @(posedge i_clk_sys) disable iff (i_reset)
    unit_c[0] && blk[0] && last_unit[0] && !(i_wr && i_addr == 8'h08)
    |=> size_cnt[0] == $past(size_hold[0]);
  endproperty
  a_size_reload: assert property (p_size_reload) else $error("size counter not reloaded");

  property p_area_restore;
    @(posedge i_clk_sys) disable iff (i_reset)
    unit_c[0] && blk[0] && last_unit[0] && !ctrl[0][`CTL_AREA_SRC] && !i_wr
    |=> dst_ptr[0] == $past(blk_start[0]);
  endproperty
  a_area_restore: assert property (p_area_restore) else $error("block pointer not restored");

  property p_end_stop;
    @(posedge i_clk_sys) disable iff (i_reset)
    end_c[0] |=> !ctrl[0][`CTL_TE] && end_flag[0] ##1 state == dma_pkg::st_idle;
  endproperty
  a_end_stop: assert property (p_end_stop) else $error("transfer did not stop at end");

  property p_read_write;
    @(posedge i_clk_sys) disable iff (i_reset)
    state == dma_pkg::st_read && i_bus_ack |=> o_bus_wr && o_bus_req && !o_bus_rd;
  endproperty
  a_read_write: assert property (p_read_write) else $error("write did not follow read");

  property p_no_ext_addr;
    @(posedge i_clk_sys) disable iff (i_reset)
    (o_bus_rd || o_bus_wr) && (o_bus_addr >= `INTERNAL_BASE) |-> !o_ext_addr_drive;
  endproperty
  a_no_ext_addr: assert property (p_no_ext_addr) else $error("external address on internal access");

  property p_priority;
    @(posedge i_clk_sys) disable iff (i_reset)
    start && ready[0] |=> act == 1'b0 && state == dma_pkg::st_req;
  endproperty
  a_priority: assert property (p_priority) else $error("channel one won over channel zero");

  property p_src_step;
    @(posedge i_clk_sys) disable iff (i_reset)
    unit_c[1] && ctrl[1][`CTL_SRC_EN] && ctrl[1][`CTL_SRC_DEC] && ctrl[1][`CTL_WORD]
    && ctrl[1][`CTL_AREA_SRC] == 1'b0 && !i_wr
    |=> src_ptr[1] == $past(src_ptr[1]) - 24'h00_0002;
  endproperty
  a_src_step: assert property (p_src_step) else $error("source pointer step wrong");

  property p_gate;
    @(posedge i_clk_sys) disable iff (i_reset)
    $rose(pending[0]) |-> $past(en[0]) && $past(blk[0]);
  endproperty
  a_gate: assert property (p_gate) else $error("disabled channel latched a request");
endmodule

// *** hw/dma_consts.svh ***
// constants for the two-channel block-transfer dma engine
`ifndef DMA_CONSTS_SVH
`define DMA_CONSTS_SVH

// =====================================================================
// structure
`define CH_COUNT        2
`define SRC_COUNT       6

// =====================================================================
// register map: i_addr[7:6] must be zero, i_addr[5] picks the channel
`define CH_SEL_BIT      5
`define OFF_SRC_PTR     5'h00
`define OFF_DST_PTR     5'h04
`define OFF_SIZE        5'h08
`define OFF_BLOCKS      5'h0C
`define OFF_CTRL        5'h10
`define OFF_STATUS      5'h14

// =====================================================================
// channel control field positions
`define CTL_TE          0
`define CTL_MTE         1
`define CTL_FULL_ADDR   2
`define CTL_BLOCK_MODE  3
`define CTL_END_IRQ_EN  4
`define CTL_ACT_SEL     5
`define CTL_WORD        6
`define CTL_SRC_EN      7
`define CTL_SRC_DEC     8
`define CTL_DST_EN      9
`define CTL_DST_DEC     10
`define CTL_AREA_SRC    11
`define CTL_SEL_LSB     12
`define CTL_SEL_MSB     14
`define CTL_BURST       15
`define STS_END         0
`define STS_BUSY        1

// =====================================================================
// request source codes and fixed addresses
`define SEL_EXTERNAL    3'h6
`define SEL_AUTO        3'h7
`define SEL_FIRST_FLAG  3'h3
`define INTERNAL_BASE   24'hFF_0000
`define ADC_RESULT_ADDR 24'hFF_FF90
`define TX_DATA_ADDR    24'hFF_FF7B
`define RX_DATA_ADDR    24'hFF_FF7D

// =====================================================================
// reset values and steps
`define CTRL_RESET      16'h0000
`define PTR_RESET       24'h00_0000
`define SIZE_RESET      8'h00
`define BLOCKS_RESET    16'h0000
`define STEP_BYTE       24'h00_0001
`define STEP_WORD       24'h00_0002

`endif

// *** hw/dma_pkg.sv ***
// types shared by the dma engine files
package dma_pkg;
  // transfer sequencer states
  typedef enum logic [2:0] {st_idle, st_req, st_read, st_write, st_step} state_t;
endpackage

// *** hw/dma_priority_pick.sv ***
// fixed-priority channel picker: lowest channel index wins
`timescale 1ns/1ps
`include "dma_consts.svh"
module dma_priority_pick (
  input  wire logic [`CH_COUNT-1:0] i_req,
  output logic                      o_any,
  output logic                      o_idx
);
  // =====================================================================
  // priority search, scanned from the lowest priority upward
  always_comb
  begin
    o_any = |i_req;
    o_idx = 1'b0;
    for (int k = `CH_COUNT - 1; k >= 0; k--)
    begin
      if (i_req[k])
      begin
        o_idx = 1'(k);
      end
    end
  end
endmodule

// *** tb/bus_memory_model.sv ***
// bus partner: memory and bus controller answering dma accesses
`timescale 1ns/1ps
module bus_memory_model (
  input  wire logic        i_clk,
  input  wire logic        i_req,
  input  wire logic        i_rd,
  input  wire logic        i_wr,
  input  wire logic [23:0] i_addr,
  input  wire logic [1:0]  i_waits,
  output logic             o_grant,
  output logic             o_ack,
  output logic      [15:0] o_rdata
);
  logic [1:0] wait_cnt;  // wait states spent on the current access
  initial
  begin
    o_grant = 1'b0;
    o_ack = 1'b0;
    o_rdata = 16'h0000;
    wait_cnt = 2'h0;
  end
  // =====================================================
  // grant follows request; ack after the programmed waits
  always @(posedge i_clk)
  begin
    o_grant <= i_req;
    o_ack <= 1'b0;
    o_rdata <= ~o_rdata;  // released data toggles, never a stale copy
    if ((i_rd || i_wr) && !o_ack)
    begin
      if (wait_cnt == i_waits)
      begin
        o_ack <= 1'b1;
        wait_cnt <= 2'h0;
        if (i_rd) o_rdata <= {i_addr[7:0], ~i_addr[7:0]};
      end
      else wait_cnt <= wait_cnt + 2'h1;
    end
  end
endmodule

// *** tb/tb_dma_block_transfer.sv ***
// self-checking bench for the block-transfer dma engine
`timescale 1ns/1ps
module tb_dma_block_transfer;
  logic i_clk_sys = 0, i_reset = 1, i_wr = 0, i_rd = 0, i_external_request_n = 1;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 0, o_rdata;
  logic [5:0] i_irq_source = 0, o_irq_clear, o_cpu_irq;
  logic [1:0] o_end_irq, waits = 2'h0;  // waits: slow memory later
  logic o_bus_req, i_bus_grant, o_bus_rd, o_bus_wr, o_bus_word, i_bus_ack, o_ext_addr_drive;
  logic [23:0] o_bus_addr, raddr = 0, waddr = 0;
  logic [15:0] o_bus_wdata, i_bus_rdata;
  int err_total = 0, cmp_count = 0, wr_seen = 0, clr_seen = 0;
  logic exp_word = 1'b0;  // unit size the running test expects on the bus
  always #5 i_clk_sys = ~i_clk_sys;
  dma_block_transfer dma_block_transfer_inst (.i_clk_sys, .i_reset, .i_addr, .i_wdata,
    .i_wr, .i_rd, .o_rdata, .i_irq_source, .i_external_request_n, .o_irq_clear,
    .o_cpu_irq, .o_end_irq, .o_bus_req, .i_bus_grant, .o_bus_addr, .o_bus_rd, .o_bus_wr,
    .o_bus_word, .o_bus_wdata, .i_bus_rdata, .i_bus_ack, .o_ext_addr_drive);
  bus_memory_model bus_memory_model_inst (.i_clk(i_clk_sys), .i_req(o_bus_req),
    .i_rd(o_bus_rd), .i_wr(o_bus_wr), .i_addr(o_bus_addr), .i_waits(waits),
    .o_grant(i_bus_grant), .o_ack(i_bus_ack), .o_rdata(i_bus_rdata));
  // =====================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (!o_bus_req && n < 50) begin @(posedge i_clk_sys); n++; end
    if (!o_bus_req) n = 400;  // a transfer that never starts is a timeout too
    while (o_bus_req && n < 400) begin @(posedge i_clk_sys); n++; end
    if (n >= 400)
    begin
      err_total++;
      wrap_up();
    end
  endtask
  task automatic wrap_up();
    $display("counts: compared %0d, mismatched %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // =====================================================
  // bus monitor: written data must be the unit just read
  always @(posedge i_clk_sys)
  begin
    if (o_bus_rd && i_bus_ack) raddr <= o_bus_addr;
    if (o_bus_wr && i_bus_ack)
    begin
      wr_seen++;
      waddr <= o_bus_addr;
      chk({16'h0000, o_bus_wdata}, {16'h0000, raddr[7:0], ~raddr[7:0]});
      chk({30'h0, o_bus_word, o_ext_addr_drive}, {30'h0, exp_word, 1'b1});
    end
    if (o_irq_clear[3]) clr_seen++;
  end
  // =====================================================
  // main sequence
  initial
  begin
    repeat (10) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    reg_rd(8'h10, 32'h0000_0000);
    reg_rd(8'h40, 32'h0000_0000);
    reg_wr(8'h00, 32'h0000_2000);
    reg_wr(8'h04, 32'h0000_1000);
    reg_wr(8'h08, 32'h0000_0202);
    reg_wr(8'h0C, 32'h0000_0002);
    reg_wr(8'h10, 32'h0000_32BF);
    @(posedge i_clk_sys) i_irq_source[3] <= 1'b1;
    @(posedge i_clk_sys) i_irq_source[3] <= 1'b0;
    wait_done();
    chk(wr_seen, 2);
    reg_rd(8'h04, 32'h0000_1000);
    reg_rd(8'h0C, 32'h0000_0001);
    @(posedge i_clk_sys) i_irq_source[3] <= 1'b1;
    @(posedge i_clk_sys) i_irq_source[3] <= 1'b0;
    wait_done();
    chk(wr_seen, 4);
    chk(clr_seen, 2);
    chk({8'h00, waddr}, 32'h0000_1001);
    reg_rd(8'h00, 32'h0000_2004);
    reg_rd(8'h10, 32'h0000_32BE);
    chk({30'h0, o_end_irq}, 32'h0000_0001);
    $display("test block transfer done");
    @(posedge i_clk_sys) i_irq_source[3] <= 1'b1;
    @(posedge i_clk_sys) i_irq_source[3] <= 1'b0;
    #1 chk({31'h0, o_cpu_irq[3]}, 32'h0000_0001);
    repeat (20) @(posedge i_clk_sys);
    chk({31'h0, o_bus_req}, 32'h0000_0000);
    $display("test disabled channel done");
    waits <= 2'h2;
    exp_word = 1'b1;
    reg_wr(8'h20, 32'h0000_0100);
    reg_wr(8'h2C, 32'h0000_0003);
    reg_wr(8'h30, 32'h0000_F1C7);
    wait_done();
    chk(wr_seen, 7);
    reg_rd(8'h20, 32'h0000_00FA);
    $display("test auto request done");
    exp_word = 1'b0;
    reg_wr(8'h2C, 32'h0000_0003);
    reg_wr(8'h30, 32'h0000_6007);
    i_external_request_n <= 1'b0;
    for (int k = 0; k < 100 && wr_seen < 8; k++) @(posedge i_clk_sys);
    if (wr_seen < 8)
    begin
      err_total++;
      wrap_up();
    end
    i_external_request_n <= 1'b1;
    repeat (40) @(posedge i_clk_sys);
    chk(wr_seen, 9);
    chk({31'h0, o_bus_req}, 32'h0000_0000);
    reg_rd(8'h2C, 32'h0000_0001);
    reg_rd(8'h30, 32'h0000_6007);
    $display("test external request done");
    wrap_up();
  end
endmodule
